// ---- core/cmd_port_pkg.sv ----
// shared constants and types of the host command port
package cmd_port_pkg;
	// command codes
	localparam logic [7:0] cmd_nop = 8'hf0;
	localparam logic [7:0] cmd_mem_read_hi = 8'h17;
	localparam logic [7:0] cmd_mstat_lo = 8'h20;
	localparam logic [7:0] cmd_mstat_hi = 8'h37;
	localparam logic [7:0] cmd_mstat2_lo = 8'h80;
	localparam logic [7:0] cmd_mstat2_hi = 8'h8e;
	localparam logic [7:0] cmd_write_lo = 8'h40;
	localparam logic [7:0] cmd_write_hi = 8'h57;
	localparam logic [7:0] cmd_trim_lo = 8'h58;
	localparam logic [7:0] cmd_trim_hi = 8'h5f;
	localparam logic [7:0] cmd_page_inc = 8'h5e;
	localparam logic [7:0] cmd_enter_normal = 8'ha8;
	localparam logic [7:0] cmd_enter_command = 8'ha9;
	localparam logic [7:0] cmd_meas_lo = 8'haa;
	localparam logic [7:0] cmd_meas_hi = 8'haf;
	// memory and page layout
	localparam int num_regs = 24;
	localparam logic [1:0] page_last = 2'h3;
	localparam logic [1:0] page_reset = 2'h0;
	// mode field values of status bits 4:3
	localparam logic [1:0] mode_normal = 2'h0;
	localparam logic [1:0] mode_command = 2'h1;
	// timing counts in clk cycles
	localparam logic [7:0] write_busy_cycles = 8'h10;
	localparam logic [1:0] strap_settle = 2'h2;
	// i2c address prefix of ten-bit addressing
	localparam logic [4:0] ten_bit_prefix = 5'h1e;
	localparam logic [3:0] bits_per_byte = 4'h8;
	typedef enum logic [2:0] {cmd_idle, cmd_args, cmd_exec, cmd_busy_write, cmd_busy_meas} cmd_state_t;
	typedef enum logic [2:0] {i2c_idle, i2c_addr, i2c_rx, i2c_ack, i2c_tx, i2c_tx_ack} i2c_state_t;
endpackage

// ---- core/spi_link_if.sv ----
// signals between the spi shift logic and the command core
`timescale 1ns/1ns
`default_nettype none
interface spi_link_if;
	logic [7:0] rx_byte;
	logic rx_toggle;
	logic rx_first;
	logic [39:0] resp;
	modport link (output rx_byte, output rx_toggle, output rx_first, input resp);
	modport core (input rx_byte, input rx_toggle, input rx_first, output resp);
endinterface
`default_nettype wire

// ---- core/spi_link.sv ----
// spi slave shifter running on the spi clock
`timescale 1ns/1ns
`default_nettype none
module spi_link
	import cmd_port_pkg::*;
(
	input wire logic rst,
	input wire logic spi_sclk,
	input wire logic spi_select,
	input wire logic spi_mosi,
	input wire logic select_active_high,
	input wire logic [1:0] spi_clock_shape_field,
	output logic spi_miso,
	spi_link_if.link lk
);
	typedef struct packed {
		logic [7:0] rx_shift;
		logic [2:0] bit_cnt;
		logic first;
		logic [39:0] tx_shift;
		logic [7:0] rx_byte;
		logic rx_first;
	} link_t;
	link_t st;
	link_t next_st;
	logic frame_idle;
	logic shift_clk;
	logic toggle;
	assign frame_idle = (spi_select != select_active_high);
	// latch edge choice; modes 00 and 11 latch on rising sclk
	assign shift_clk = spi_sclk ^ (spi_clock_shape_field[1] ^ spi_clock_shape_field[0]);
	assign lk.rx_byte = st.rx_byte;
	assign lk.rx_first = st.rx_first;
	assign lk.rx_toggle = toggle;
	// shift in on the latch edge, capture the response at frame start
	always_comb begin
		next_st = st;
		next_st.rx_shift = {st.rx_shift[6:0], spi_mosi};
		next_st.bit_cnt = st.bit_cnt + 3'h1;
		next_st.tx_shift = {st.tx_shift[38:0], 1'b0};
		// status goes out at any frame
		if (st.first && st.bit_cnt == 3'h0)
			next_st.tx_shift = {lk.resp[38:0], 1'b0};
		if (st.bit_cnt == 3'h7) begin
			next_st.rx_byte = {st.rx_shift[6:0], spi_mosi};
			next_st.rx_first = st.first;
			next_st.first = 1'b0;
		end
	end
	// frame state clears whenever select is inactive; the clock may stop then
	always_ff @(posedge shift_clk or posedge frame_idle) begin
		if (frame_idle) begin
			st <= '{rx_shift: 8'h00, bit_cnt: 3'h0, first: 1'b1, tx_shift: 40'h0,
				rx_byte: 8'h00, rx_first: 1'b0};
		end else begin
			st <= next_st;
		end
	end
	// byte event toggle, survives frame ends
	always_ff @(posedge shift_clk or posedge rst) begin
		if (rst) begin
			toggle <= 1'b0;
		end else if (!frame_idle && st.bit_cnt == 3'h7) begin
			toggle <= ~toggle;
		end
	end
	// miso changes on the output edge; first bit is status bit 7, always zero
	always_ff @(negedge shift_clk or posedge frame_idle) begin
		if (frame_idle) begin
			spi_miso <= 1'b0;
		end else begin
			spi_miso <= st.tx_shift[39];
		end
	end
endmodule
`default_nettype wire

// ---- core/sensor_host_port.sv ----
// host command port of the sensor conditioner: decode, page memory, i2c slave
// Functional notes
// - read commands: status bit 1 data corrected, bit 0 alu saturation
// - write commands: status bit 1 memory full or write rejected, bit 0 zero
// - status bits 4:3 carry the operating mode
// - end of conversion rises when measurement and correction are done
// - strap low selects the spi slave
// - spi clock phase from bit 10, polarity from bit 11
// - select active level from bit 9, zero means active low
// - a nop frame returns the current status on miso
// - nop plus two zero bytes returns status, data high, data low
// - strap high selects the i2c slave
// - i2c slave never stretches the clock, ignores ten-bit addresses
// - page counter starts at zero, 5e steps it up to three
// - each register programs once per page
// - page advance clears all registers of the old page
// - past the last page every memory change is refused
// - commands 40 to 57 write customer registers
// - trim page writes are refused
// - memory status commands return corrected flag and current page
// - status shows powered, busy, checksum error; busy ignores commands
// - nop keeps response data, any other command discards it
`timescale 1ns/1ns
`default_nettype none
module sensor_host_port
	import cmd_port_pkg::*;
#(
	parameter logic [7:0] write_busy = write_busy_cycles
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic iface_select,
	input wire logic spi_sclk,
	input wire logic spi_select,
	input wire logic spi_mosi,
	output logic spi_miso,
	input wire logic select_active_high,
	input wire logic [1:0] spi_clock_shape_field,
	input wire logic i2c_scl_in,
	input wire logic i2c_sda_in,
	output logic i2c_sda_out,
	output logic i2c_sda_oe,
	input wire logic [6:0] i2c_slave_address,
	input wire logic checksum_failed,
	input wire logic mem_corrected,
	input wire logic alu_saturated,
	input wire logic conv_done,
	input wire logic [15:0] bridge_result_word,
	input wire logic [15:0] temperature_result_word,
	output logic meas_start,
	output logic end_of_conversion,
	output logic [1:0] current_page,
	output logic [15:0] memory_read_word
);
	typedef struct packed {
		logic [1:0] strap_sync;
		logic [1:0] strap_wait;
		logic strapped;
		logic strap_i2c;
		logic powered;
		logic mem_err;
		logic [1:0] sel_sync;
		logic [2:0] tgl_sync;
		logic [2:0] scl_sync;
		logic [2:0] sda_sync;
		cmd_state_t cmd_state;
		logic [7:0] cmd;
		logic arg_seen;
		logic [7:0] arg_hi;
		logic [15:0] arg;
		logic [7:0] busy_cnt;
		logic [1:0] mode;
		logic [1:0] page;
		logic [num_regs-1:0][15:0] mem;
		logic [num_regs-1:0] programmed;
		logic flag1;
		logic flag0;
		logic [31:0] data;
		logic [39:0] resp;
		logic eoc;
		logic meas_start;
		i2c_state_t i2c_state;
		logic [7:0] i2c_shift;
		logic [3:0] i2c_bits;
		logic i2c_read;
		logic [2:0] i2c_tx_idx;
		logic i2c_first;
		logic sda_oe;
	} core_t;
	core_t st;
	core_t next_st;
	spi_link_if lk();
	logic busy;
	logic [7:0] status_byte;
	logic [39:0] resp_word;
	logic spi_byte;
	logic i2c_byte;
	logic byte_valid;
	logic byte_first;
	logic [7:0] byte_val;
	logic scl_rise;
	logic scl_fall;
	logic i2c_start;
	logic i2c_stop;
	logic [7:0] tx_first;
	logic [7:0] tx_next;
	logic [7:0] wr_diff;
	logic [4:0] wr_idx;
	logic is_rd, is_ms, is_wr, is_pg, is_trim, is_meas;

	spi_link link (
		.rst(rst),
		.spi_sclk(spi_sclk),
		.spi_select(spi_select),
		.spi_mosi(spi_mosi),
		.select_active_high(select_active_high),
		.spi_clock_shape_field(spi_clock_shape_field),
		.spi_miso(spi_miso),
		.lk(lk)
	);

	// byte i of status plus data word, zero past the end
	function automatic logic [7:0] tx_byte(input logic [39:0] w, input logic [2:0] i);
		logic [39:0] t;
		t = w << {i, 3'h0};
		return t[39:32];
	endfunction

	assign busy = (st.cmd_state != cmd_idle);
	// bit 7 fixed zero; mode field
	assign status_byte = {1'b0, st.powered, busy, st.mode, st.mem_err, st.flag1, st.flag0};
	// status, then data high byte, then low byte
	assign resp_word = {status_byte, st.data};
	assign tx_first = tx_byte(resp_word, 3'h0);
	assign tx_next = tx_byte(resp_word, st.i2c_tx_idx);
	// spi bytes count only with the strap low
	assign spi_byte = st.strapped && !st.strap_i2c && (st.tgl_sync[2] ^ st.tgl_sync[1]);
	assign scl_rise = st.scl_sync[1] && !st.scl_sync[2];
	assign scl_fall = !st.scl_sync[1] && st.scl_sync[2];
	assign i2c_start = st.scl_sync[1] && st.scl_sync[2] && !st.sda_sync[1] && st.sda_sync[2];
	assign i2c_stop = st.scl_sync[1] && st.scl_sync[2] && st.sda_sync[1] && !st.sda_sync[2];
	assign i2c_byte = (st.i2c_state == i2c_rx) && scl_fall && (st.i2c_bits == bits_per_byte);
	assign byte_valid = spi_byte || i2c_byte;
	assign byte_first = st.strap_i2c ? st.i2c_first : lk.rx_first;
	assign byte_val = st.strap_i2c ? st.i2c_shift : lk.rx_byte;
	// command class decode
	assign wr_diff = st.cmd - cmd_write_lo;
	assign wr_idx = wr_diff[4:0];
	assign is_rd = (st.cmd <= cmd_mem_read_hi);
	assign is_ms = (st.cmd >= cmd_mstat_lo && st.cmd <= cmd_mstat_hi) ||
		(st.cmd >= cmd_mstat2_lo && st.cmd <= cmd_mstat2_hi);
	assign is_wr = (st.cmd >= cmd_write_lo && st.cmd <= cmd_write_hi);
	assign is_pg = (st.cmd == cmd_page_inc);
	assign is_trim = (st.cmd >= cmd_trim_lo && st.cmd <= cmd_trim_hi) && !is_pg;
	assign is_meas = (st.cmd >= cmd_meas_lo && st.cmd <= cmd_meas_hi);

	// next state of the whole core
	always_comb begin
		next_st = st;
		next_st.meas_start = 1'b0;
		next_st.strap_sync = {st.strap_sync[0], iface_select};
		next_st.sel_sync = {st.sel_sync[0], spi_select};
		next_st.tgl_sync = {st.tgl_sync[1:0], lk.rx_toggle};
		next_st.scl_sync = {st.scl_sync[1:0], i2c_scl_in};
		next_st.sda_sync = {st.sda_sync[1:0], i2c_sda_in};
		// strap and power-up checksum caught once after reset
		if (!st.strapped) begin
			if (st.strap_wait == strap_settle) begin
				next_st.strapped = 1'b1;
				next_st.strap_i2c = st.strap_sync[1];
				next_st.mem_err = checksum_failed;
				next_st.powered = 1'b1;
			end else begin
				next_st.strap_wait = st.strap_wait + 2'h1;
			end
		end
		unique case (st.cmd_state)
			// only idle takes commands; nop keeps data
			cmd_idle: if (byte_valid && byte_first && byte_val != cmd_nop) begin
				next_st.cmd = byte_val;
				next_st.data = 32'h0;
				next_st.arg_seen = 1'b0;
				if (byte_val >= cmd_write_lo && byte_val <= cmd_write_hi) begin
					next_st.cmd_state = cmd_args;
				end else begin
					next_st.cmd_state = cmd_exec;
				end
			end
			cmd_args: if (byte_valid) begin
				if (byte_first) begin
					next_st.cmd_state = cmd_idle; // short frame abandons the write
				end else if (!st.arg_seen) begin
					next_st.arg_hi = byte_val;
					next_st.arg_seen = 1'b1;
				end else begin
					next_st.arg = {st.arg_hi, byte_val};
					next_st.cmd_state = cmd_exec;
				end
			end
			cmd_exec: begin
				next_st.cmd_state = cmd_idle;
				next_st.flag0 = 1'b0;
				if (is_rd) begin
					next_st.data = {st.mem[st.cmd[4:0]], 16'h0};
					next_st.flag1 = mem_corrected;
					next_st.flag0 = alu_saturated;
				end else if (is_ms) begin
					next_st.data = {mem_corrected, st.page, 13'h0, 16'h0};
					next_st.flag1 = mem_corrected;
				end else if (is_wr) begin
					if (st.programmed[wr_idx]) begin
						next_st.flag1 = 1'b1; // rejected
					end else begin
						next_st.mem[wr_idx] = st.arg;
						next_st.programmed[wr_idx] = 1'b1;
						next_st.flag1 = 1'b0;
						next_st.busy_cnt = write_busy;
						next_st.cmd_state = cmd_busy_write;
					end
				end else if (is_pg) begin
					// no page past the last one
					if (st.page == page_last) begin
						next_st.flag1 = 1'b1;
					end else begin
						// step by one; old page gone
						next_st.page = st.page + 2'h1;
						next_st.mem = '0;
						next_st.programmed = '0;
						next_st.flag1 = 1'b0;
						next_st.busy_cnt = write_busy;
						next_st.cmd_state = cmd_busy_write;
					end
				end else if (is_trim) begin
					next_st.flag1 = 1'b1;
				end else if (is_meas) begin
					next_st.meas_start = 1'b1;
					next_st.eoc = 1'b0;
					next_st.cmd_state = cmd_busy_meas;
				end else if (st.cmd == cmd_enter_command) begin
					next_st.mode = mode_command;
				end else if (st.cmd == cmd_enter_normal) begin
					next_st.mode = mode_normal;
				end
			end
			cmd_busy_write: begin
				next_st.busy_cnt = st.busy_cnt - 8'h1;
				if (st.busy_cnt <= 8'h1)
					next_st.cmd_state = cmd_idle;
			end
			// conversion result and end of conversion
			cmd_busy_meas: if (conv_done) begin
				next_st.data = {bridge_result_word, temperature_result_word};
				next_st.flag1 = 1'b0;
				next_st.flag0 = alu_saturated;
				next_st.eoc = 1'b1;
				next_st.cmd_state = cmd_idle;
			end
		endcase
		// response handed to the spi side only between frames
		if (st.sel_sync[1] != select_active_high)
			next_st.resp = resp_word;
		// i2c slave; sda only, scl never held
		if (!st.strap_i2c || i2c_stop) begin
			next_st.i2c_state = i2c_idle;
			next_st.sda_oe = 1'b0;
		end else if (i2c_start) begin
			next_st.i2c_state = i2c_addr;
			next_st.i2c_bits = 4'h0;
			next_st.sda_oe = 1'b0;
		end else begin
			unique case (st.i2c_state)
				i2c_idle: begin
				end
				i2c_addr, i2c_rx: if (scl_rise) begin
					next_st.i2c_shift = {st.i2c_shift[6:0], st.sda_sync[1]};
					next_st.i2c_bits = st.i2c_bits + 4'h1;
				end else if (scl_fall && st.i2c_bits == bits_per_byte) begin
					next_st.i2c_bits = 4'h0;
					if (st.i2c_state == i2c_rx) begin
						next_st.sda_oe = 1'b1;
						next_st.i2c_first = 1'b0;
						next_st.i2c_state = i2c_ack;
					end else if (st.i2c_shift[7:1] == i2c_slave_address &&
						st.i2c_shift[7:3] != ten_bit_prefix) begin
						next_st.sda_oe = 1'b1;
						next_st.i2c_read = st.i2c_shift[0];
						next_st.i2c_first = 1'b1;
						next_st.i2c_state = i2c_ack;
					end else begin
						next_st.i2c_state = i2c_idle;
					end
				end
				i2c_ack: if (scl_fall) begin
					if (st.i2c_read) begin
						next_st.sda_oe = ~tx_first[7];
						next_st.i2c_shift = {tx_first[6:0], 1'b0};
						next_st.i2c_bits = 4'h1;
						next_st.i2c_tx_idx = 3'h1;
						next_st.i2c_state = i2c_tx;
					end else begin
						next_st.sda_oe = 1'b0;
						next_st.i2c_state = i2c_rx;
					end
				end
				i2c_tx: if (scl_fall) begin
					if (st.i2c_bits == bits_per_byte) begin
						next_st.sda_oe = 1'b0;
						next_st.i2c_state = i2c_tx_ack;
					end else begin
						next_st.sda_oe = ~st.i2c_shift[7];
						next_st.i2c_shift = {st.i2c_shift[6:0], 1'b0};
						next_st.i2c_bits = st.i2c_bits + 4'h1;
					end
				end
				i2c_tx_ack: if (scl_rise) begin
					if (st.sda_sync[1]) begin
						next_st.i2c_state = i2c_idle;
					end else begin
						next_st.i2c_shift = tx_next;
						next_st.i2c_tx_idx = st.i2c_tx_idx + 3'h1;
						next_st.i2c_bits = 4'h0;
						next_st.i2c_state = i2c_tx;
					end
				end
			endcase
		end
	end

	// register the core state
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
			st.cmd_state <= cmd_idle;
			st.i2c_state <= i2c_idle;
			st.page <= page_reset;
			st.mode <= mode_normal;
		end else begin
			st <= next_st;
		end
	end

	assign lk.resp = st.resp;
	assign i2c_sda_out = 1'b0; // open drain: only ever pulls low
	assign i2c_sda_oe = st.sda_oe;
	assign meas_start = st.meas_start;
	assign end_of_conversion = st.eoc;
	assign current_page = st.page;
	assign memory_read_word = st.data[31:16];

	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence seq_write_taken;
		st.cmd_state == cmd_exec && is_wr;
	endsequence
	sequence seq_page_step;
		st.cmd_state == cmd_exec && is_pg;
	endsequence
	a_status_top_zero: assert property (st.i2c_read && scl_fall &&
		st.i2c_state == i2c_ack |=> i2c_sda_oe)
		else $error("status bit 7 not zero");
	a_mode_field: assert property (st.cmd_state == cmd_exec &&
		st.cmd == cmd_enter_command |=> status_byte[4:3] == mode_command)
		else $error("mode field wrong");
	a_page_monotone: assert property ((st.page != $past(st.page)) |->
		(st.page == $past(st.page) + 2'h1))
		else $error("page moved other than up by one");
	a_write_once: assert property ((seq_write_taken ##0 st.programmed[wr_idx]) |=>
		(st.flag1 && st.mem == $past(st.mem)))
		else $error("register programmed twice");
	a_page_clears: assert property (seq_page_step ##0 (st.page != page_last) |=>
		(st.programmed == '0 && st.mem == '0))
		else $error("old page contents kept");
	a_last_page_refused: assert property (seq_page_step ##0 (st.page == page_last) |=>
		(st.flag1 && st.page == page_last && $stable(st.mem)))
		else $error("change past last page");
	a_trim_refused: assert property ((st.cmd_state == cmd_exec && is_trim) |=>
		(st.flag1 && $stable(st.mem)))
		else $error("trim write accepted");
	a_busy_ignores: assert property ((busy && st.cmd_state != cmd_args) |=>
		$stable(st.cmd))
		else $error("command taken while busy");
	a_eoc_on_done: assert property ((st.cmd_state == cmd_busy_meas && conv_done) |=>
		(end_of_conversion && !busy)[*2])
		else $error("end of conversion missed");
	a_nop_keeps: assert property ((!busy && byte_valid && byte_first && byte_val == cmd_nop) |=>
		$stable(st.data))
		else $error("nop lost response data");
	a_spi_quiet_i2c: assert property (!st.strap_i2c |-> !i2c_sda_oe)
		else $error("sda driven in spi mode");
endmodule
`default_nettype wire

// ---- dv/spi_host_model.sv ----
// spi master model that sends frames of up to five bytes
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
	input wire logic miso,
	input wire logic sel_hi,
	input wire logic [1:0] shape,
	output var logic sclk,
	output var logic sel,
	output var logic mosi
);
	// lines idle and deselected at time zero
	initial begin
		sclk = 1'b0;
		sel = 1'b1;
		mosi = 1'b0;
	end
	// one frame, msb first; replies come back left aligned in rx
	task automatic xfer(input int n, input logic [39:0] tx, output logic [39:0] rx);
		logic [39:0] s;
		s = tx;
		rx = '0;
		sel = ~sel_hi;
		sclk = shape[1];
		#64;
		sel = sel_hi;
		mosi = s[39];
		#40;
		for (int i = 0; i < 8 * n; i++) begin
			if (shape[0]) begin
				sclk = ~sclk;
				mosi = s[39];
				#32;
			end
			rx[39 - i] = miso;
			sclk = ~sclk;
			s = s << 1;
			#32;
			if (!shape[0]) begin
				sclk = ~sclk;
				mosi = s[39];
				#32;
			end
		end
		#32;
		// released data line no longer shows the last bit
		sel = ~sel_hi;
		mosi = ~mosi;
		#96;
	endtask
endmodule
`default_nettype wire

// ---- dv/sensor_host_port_test.sv ----
// self-checking bench of the host command port
`timescale 1ns/1ns
`default_nettype none
module sensor_host_port_test;
	import cmd_port_pkg::*;
	logic clk, rst, iface_select, sel_hi, ck_fail, corr, sat, conv_done, scl, sda_m;
	logic [1:0] shape;
	logic [15:0] bridge, temp;
	wire logic sclk, sel, mosi, miso, sda_oe, sda_o, meas_start, eoc;
	wire logic [1:0] page;
	wire logic [15:0] mrw;
	wire logic sda_line = sda_m & (sda_o | ~sda_oe);
	int error_cnt, checked, seed, md, pg, starts;
	logic [15:0] mem [num_regs];
	bit wr [num_regs];
	logic [39:0] rx;
	logic [23:0] v3;

	sensor_host_port #(.write_busy(8'hc8)) i_sensor_host_port (
		.clk(clk), .rst(rst), .iface_select(iface_select), .spi_sclk(sclk),
		.spi_select(sel), .spi_mosi(mosi), .spi_miso(miso), .select_active_high(sel_hi),
		.spi_clock_shape_field(shape), .i2c_scl_in(scl), .i2c_sda_in(sda_line),
		.i2c_sda_out(sda_o), .i2c_sda_oe(sda_oe), .i2c_slave_address(7'h2a),
		.checksum_failed(ck_fail), .mem_corrected(corr), .alu_saturated(sat),
		.conv_done(conv_done), .bridge_result_word(bridge), .temperature_result_word(temp),
		.meas_start(meas_start), .end_of_conversion(eoc), .current_page(page),
		.memory_read_word(mrw));
	spi_host_model i_spi_host_model (.miso(miso), .sel_hi(sel_hi), .shape(shape),
		.sclk(sclk), .sel(sel), .mosi(mosi));

	always #4 clk = ~clk;
	// count measurement starts
	always @(posedge clk) if (meas_start === 1'b1) starts <= starts + 1;
	// watchdog against a hang
	initial begin
		#700000;
		error_cnt++;
		conclude();
	end

	task automatic conclude();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// expected status byte of the model
	function automatic logic [7:0] st(input logic b1, input logic b0);
		return {2'b01, 1'b0, md[1:0], ck_fail, b1, b0};
	endfunction
	task automatic cmd(input logic [7:0] c, input logic [15:0] arg, input int n);
		i_spi_host_model.xfer(n, {c, arg, 16'h0}, rx);
	endtask
	// poll status with nop frames until not busy
	task automatic idle();
		for (int i = 0; i < 30; i++) begin
			cmd(cmd_nop, 16'h0, 1);
			if (rx[37] === 1'b0) return;
		end
		error_cnt++;
		conclude();
	endtask
	task automatic wr_reg(input int idx, input logic [15:0] v);
		logic rej;
		rej = idx >= num_regs || wr[idx];
		cmd(8'(cmd_write_lo + idx), v, 3);
		idle();
		chk({8'h0, rx[39:32] & 8'hfe}, {8'h0, st(rej, 1'b0)});
		if (!rej) begin
			mem[idx] = v;
			wr[idx] = 1'b1;
		end
	endtask
	task automatic rd_reg(input int idx);
		{corr, sat} = 2'($random(seed));
		cmd(8'(idx), 16'h0, 1);
		idle();
		i_spi_host_model.xfer(3, {cmd_nop, 32'h0}, rx);
		chk({8'h0, rx[39:32]}, {8'h0, st(corr, sat)});
		chk(rx[31:16], mem[idx]);
		chk(mrw, mem[idx]);
	endtask
	task automatic i2c_bit(input logic b, output logic r);
		sda_m = b;
		#400 scl = 1'b1;
		#400 r = sda_line;
		#400 scl = 1'b0;
	endtask
	task automatic i2c_byte(input logic [7:0] b, input logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) i2c_bit(b[i], r);
		i2c_bit(1'b1, r);
		chk({15'h0, r}, {15'h0, ~ack});
	endtask
	task automatic i2c_frame(input logic [7:0] a, input logic ack);
		sda_m = 1'b0;
		#400 scl = 1'b0;
		i2c_byte(a, ack);
		// normal speed: address plus the one byte that 5e needs
		if (ack) i2c_byte(cmd_page_inc, 1'b1);
		sda_m = 1'b0;
		#400 scl = 1'b1;
		#400 sda_m = 1'b1;
		#400;
	endtask
	// read transfer: status, data high, data low, nack on the last byte
	task automatic i2c_rd3(output logic [23:0] v);
		logic r;
		sda_m = 1'b0;
		#400 scl = 1'b0;
		i2c_byte({7'h2a, 1'b1}, 1'b1);
		for (int i = 23; i >= 0; i--) begin
			i2c_bit(1'b1, r);
			v[i] = r;
			if (i % 8 == 0) i2c_bit(i == 0, r);
		end
		sda_m = 1'b0;
		#400 scl = 1'b1;
		#400 sda_m = 1'b1;
		#400;
	endtask

	initial begin
		seed = 38;
		{clk, rst, iface_select, sel_hi, conv_done, scl, sda_m, starts} = {7'h23, 32'h0};
		{ck_fail, corr, sat} = 3'($random(seed));
		{shape, bridge, temp} = '0;
		for (int j = 0; j < num_regs; j++) {wr[j], mem[j]} = '0;
		repeat (4) @(posedge clk);
		#1 rst = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		// every clock shape and select level, alternating modes
		for (int k = 0; k < 8; k++) begin
			{sel_hi, shape} = 3'(k);
			md = k % 2;
			cmd(md ? cmd_enter_command : cmd_enter_normal, 16'h0, 1);
			cmd(cmd_nop, 16'h0, 1);
			chk({8'h0, rx[39:32] & 8'hfc}, {8'h0, st(1'b0, 1'b0)});
		end
		// a command sent while busy is ignored
		cmd(8'h41, 16'h1234, 3);
		cmd(cmd_enter_normal, 16'h0, 1);
		cmd(cmd_nop, 16'h0, 1);
		chk({8'h0, rx[39:32] & 8'hfe}, {8'h0, st(1'b0, 1'b0) | 8'h20});
		idle();
		chk({8'h0, rx[39:32] & 8'hfe}, {8'h0, st(1'b0, 1'b0)});
		{wr[1], mem[1]} = {1'b1, 16'h1234};
		wr_reg(0, 16'($random(seed)));
		wr_reg(23, 16'($random(seed)));
		rd_reg(0);
		rd_reg(23);
		for (int p = 0; p < 5; p++) begin
			if (p > 0) begin
				cmd(cmd_page_inc, 16'h0, 1);
				idle();
				chk({8'h0, rx[39:32] & 8'hfe}, {8'h0, st(p > 3, 1'b0)});
				if (p < 4) begin
					pg = p;
					for (int j = 0; j < num_regs; j++) {wr[j], mem[j]} = '0;
				end
			end
			chk({14'h0, page}, {14'h0, pg[1:0]});
			cmd(cmd_mstat_lo, 16'h0, 1);
			idle();
			i_spi_host_model.xfer(3, {cmd_nop, 32'h0}, rx);
			chk({13'h0, rx[31:29]}, {13'h0, corr, pg[1:0]});
			rd_reg(1);
			wr_reg(1, 16'($random(seed)));
			wr_reg(1, 16'($random(seed)));
			wr_reg(24, 16'($random(seed)));
			rd_reg(1);
		end
		// measurement, then end of conversion and four data bytes
		cmd(cmd_meas_lo + 8'h2, 16'h0, 1);
		chk(16'(starts), 16'h1);
		chk({15'h0, eoc}, 16'h0);
		{bridge, temp} = $random(seed);
		@(posedge clk) #1 conv_done = 1'b1;
		@(posedge clk) #1 conv_done = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk({15'h0, eoc}, 16'h1);
		idle();
		for (int r = 0; r < 2; r++) begin
			i_spi_host_model.xfer(5, {cmd_nop, 32'h0}, rx);
			chk(rx[31:16], bridge);
			chk(rx[15:0], temp);
		end
		cmd(cmd_enter_command, 16'h0, 1);
		i_spi_host_model.xfer(5, {cmd_nop, 32'h0}, rx);
		chk(rx[31:16] | rx[15:0], 16'h0);
		// strap high: i2c slave, ten-bit prefix ignored, own address steps the page
		iface_select = 1'b1;
		@(posedge clk) #1 rst = 1'b1;
		repeat (4) @(posedge clk);
		#1 rst = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		i2c_frame({ten_bit_prefix, 2'b01, 1'b0}, 1'b0);
		i2c_frame({7'h2a, 1'b0}, 1'b1);
		repeat (20) @(posedge clk);
		chk({14'h0, page}, 16'h1);
		// reset brought normal mode back; page step left zero data
		md = 0;
		i2c_rd3(v3);
		chk({8'h0, v3[23:16] & 8'hfe}, {8'h0, st(1'b0, 1'b0)});
		chk(v3[15:0], 16'h0);
		conclude();
	end
endmodule
`default_nettype wire
